//--- hw/seoc_pkg.sv
package seoc_pkg;
  // ==========================================
  // Sizes
  localparam int NUM_PINS = 12;
  localparam int NUM_CHAN = 16;
  localparam int PAGE_W = 4;
  localparam int CFG_W = 32;

  // ==========================================
  // Register map
  localparam logic [7:0] CMD_OUT_CFG = 8'hD2;
  localparam logic [31:0] CFG_RESET = 32'h0000_0002;
  localparam logic [31:0] CFG_WR_MASK = 32'hFFFF_00C7;

  // ==========================================
  // Field positions
  localparam int MASK_LSB = 16;
  localparam int DRIVE_BIT = 7;
  localparam int POL_BIT = 6;
  localparam int FUNC_LSB = 0;

  // ==========================================
  // Special-function pages
  localparam logic [PAGE_W-1:0] PAGE_FAULT = 4'hA;
  localparam logic [PAGE_W-1:0] PAGE_LINK = 4'hB;

  typedef enum logic [2:0] {
    FN_SUPPLY = 3'b000,
    FN_FORCE_ON = 3'b001,
    FN_FORCE_OFF = 3'b010,
    FN_AND = 3'b011,
    FN_OR = 3'b100,
    FN_SPECIAL = 3'b101,
    FN_RSVD0 = 3'b110,
    FN_RSVD1 = 3'b111
  } seoc_func_t;

  typedef struct packed {
    logic [15:0] chan_mask;
    logic [7:0] zero_hi;
    logic drive_type_bit;
    logic polarity_bit;
    logic [2:0] zero_lo;
    seoc_func_t func;
  } seoc_cfg_t;

  typedef struct packed {
    logic out;
    logic oe;
  } seoc_pin_t;
endpackage

//--- hw/seoc_func_sel.sv
`timescale 1ns/1ns
module seoc_func_sel #(
  parameter logic [3:0] PAGE = 4'h0
) (
  input wire seoc_pkg::seoc_cfg_t cfg,
  input wire logic sequencer_en,
  input wire logic [15:0] and_src,
  input wire logic [15:0] alarm,
  input wire logic special_in,
  output logic asserted
);
  // ==========================================
  // Function selection, before polarity
  always_comb begin
    unique case (cfg.func)
      seoc_pkg::FN_SUPPLY: asserted = sequencer_en; // [R2]
      seoc_pkg::FN_FORCE_ON: asserted = 1'b1; // [R3]
      seoc_pkg::FN_FORCE_OFF: asserted = 1'b0; // [R4]
      // Mask excludes channels by forcing their term true
      seoc_pkg::FN_AND: asserted = &(and_src | ~cfg.chan_mask); // [R5] [R7] [R8]
      seoc_pkg::FN_OR: asserted = |(alarm & cfg.chan_mask); // [R6] [R7] [R8]
      seoc_pkg::FN_SPECIAL: // [R9]
        asserted = ((PAGE == seoc_pkg::PAGE_FAULT) || (PAGE == seoc_pkg::PAGE_LINK)) ?
                   special_in : 1'b0;
      default: asserted = 1'b0; // [R9]
    endcase
  end
endmodule // seoc_func_sel

//--- hw/seoc_pin_drv.sv
`timescale 1ns/1ns
module seoc_pin_drv (
  input wire logic asserted,
  input wire logic polarity_bit,
  input wire logic drive_type_bit,
  output seoc_pkg::seoc_pin_t pin
);
  logic level;
  // ==========================================
  // Polarity and drive after selection
  always_comb begin
    level = polarity_bit ? asserted : ~asserted; // [R11] [R15]
    pin.out = drive_type_bit ? 1'b0 : level; // [R10] [R15]
    pin.oe = drive_type_bit ? ~level : 1'b1; // [R10]
  end
endmodule // seoc_pin_drv

//--- hw/seoc_top.sv
// Notes on behaviour
// [R1] Twelve output pins 0..11, each with its own config chosen by page.
// [R2] Function 000 follows the sequencer enable for that channel.
// [R3] Function 001 holds the output asserted.
// [R4] Function 010 holds the output deasserted.
// [R5] Function 011 asserts when every masked-in power-good or general input is set.
// [R6] Function 100 asserts when any masked-in alarm is active.
// [R7] Channel N is controlled by mask bit N plus 16.
// [R8] Mask bits matter only in functions 011 and 100.
// [R9] Function 101 is special on pages 10 and 11; 110 and 111 reserved.
// [R10] Bit 7 picks push-pull at 0 or open-drain at 1.
// [R11] Bit 6 picks asserted-low at 0 or asserted-high at 1.
// [R12] Bits 15:8 and 5:3 always read as zero.
// [R13] Host sets channel select to 10h when using supply-enable mode.
// [R14] Host avoids rewriting the config while supplies run.
// [R15] Polarity and drive type apply after function selection in all modes.
`timescale 1ns/1ns
module seoc_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] page,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic [31:0] cmd_wdata,
  output logic [31:0] cmd_rdata,
  input wire logic [11:0] sequencer_enable,
  input wire logic [15:0] power_good,
  input wire logic [15:0] general_input,
  input wire logic [15:0] src_sel,
  input wire logic [15:0] chan_alarm,
  input wire logic fault_line_two_in,
  input wire logic ordering_link_line_in,
  output logic [11:0] supply_enable_output,
  output logic [11:0] supply_enable_output_oe
);
  // ==========================================
  // Pin input synchronisers
  logic [63:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic [1:0] ssync1_reg, ssync1_next, ssync2_reg, ssync2_next;
  always_comb begin
    sync1_next = {power_good, general_input, src_sel, chan_alarm};
    sync2_next = sync1_reg;
    ssync1_next = {fault_line_two_in, ordering_link_line_in};
    ssync2_next = ssync1_reg;
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= 64'h0;
      sync2_reg <= 64'h0;
      ssync1_reg <= 2'h0;
      ssync2_reg <= 2'h0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      ssync1_reg <= ssync1_next;
      ssync2_reg <= ssync2_next;
    end
  end
  logic [15:0] pwr_s, gi_s, sel_s, al_s, and_src;
  assign pwr_s = sync2_reg[63:48];
  assign gi_s = sync2_reg[47:32];
  assign sel_s = sync2_reg[31:16];
  assign al_s = sync2_reg[15:0];
  // Per channel, the input source chosen by a strap-like select
  assign and_src = (pwr_s & ~sel_s) | (gi_s & sel_s);

  // ==========================================
  // Configuration, one copy per page 0..11
  logic [31:0] cfg_reg [seoc_pkg::NUM_PINS];
  logic [31:0] cfg_next [seoc_pkg::NUM_PINS];
  logic page_ok;
  assign page_ok = page < 4'(seoc_pkg::NUM_PINS);
  always_comb begin
    for (int i = 0; i < seoc_pkg::NUM_PINS; i++) begin
      cfg_next[i] = cfg_reg[i];
      if (cmd_wr && cmd_code == seoc_pkg::CMD_OUT_CFG && page_ok && page == 4'(i)) begin // [R1]
        cfg_next[i] = cmd_wdata & seoc_pkg::CFG_WR_MASK; // [R12]
      end
    end
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < seoc_pkg::NUM_PINS; i++) begin
        cfg_reg[i] <= seoc_pkg::CFG_RESET;
      end
    end else begin
      for (int i = 0; i < seoc_pkg::NUM_PINS; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
    end
  end

  // ==========================================
  // Read-back, registered; unknown command or page reads zero
  logic [31:0] rdata_reg, rdata_next;
  always_comb begin
    rdata_next = 32'h0;
    if (cmd_code == seoc_pkg::CMD_OUT_CFG && page_ok) begin
      rdata_next = cfg_reg[page] & seoc_pkg::CFG_WR_MASK; // [R12]
    end
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign cmd_rdata = rdata_reg;

  // ==========================================
  // Per-pin selection and drive
  logic [11:0] out_reg, out_next, oe_reg, oe_next;
  genvar g;
  generate
    for (g = 0; g < seoc_pkg::NUM_PINS; g++) begin : g_pin // [R1]
      logic asrt;
      seoc_pkg::seoc_pin_t pin;
      logic spec;
      assign spec = (4'(g) == seoc_pkg::PAGE_FAULT) ? ssync2_reg[1] : ssync2_reg[0];
      seoc_func_sel #(.PAGE(4'(g))) u_sel (
        .cfg(seoc_pkg::seoc_cfg_t'(cfg_reg[g])),
        .sequencer_en(sequencer_enable[g]), // [R2]
        .and_src(and_src),
        .alarm(al_s),
        .special_in(spec),
        .asserted(asrt)
      );
      seoc_pin_drv u_drv (
        .asserted(asrt),
        .polarity_bit(cfg_reg[g][seoc_pkg::POL_BIT]),
        .drive_type_bit(cfg_reg[g][seoc_pkg::DRIVE_BIT]),
        .pin(pin)
      );
      assign out_next[g] = pin.out; // [R15]
      assign oe_next[g] = pin.oe;
    end
  endgenerate
  // Registered so the pins never glitch on input skew
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_reg <= 12'h000;
      oe_reg <= 12'h000;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end
  assign supply_enable_output = out_reg;
  assign supply_enable_output_oe = oe_reg;
endmodule // seoc_top

//--- dv/seoc_supply_model.sv
`timescale 1ns/1ns
// ==========
// Supplies: each powers up while its pin is high
module seoc_supply_model (
  input wire logic sys_clk,
  input wire logic [11:0] pin_out,
  input wire logic [11:0] pin_oe,
  output logic [11:0] pin_level,
  output logic [15:0] power_good
);
  // Pull-up sets a released pin high
  assign pin_level = (pin_out & pin_oe) | ~pin_oe;
  always_ff @(posedge sys_clk) power_good <= {4'h0, pin_level};
endmodule // seoc_supply_model

//--- dv/seoc_top_asserts.sv
`timescale 1ns/1ns
// ==========
// Config checks
module seoc_top_asserts (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] page,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic [31:0] cmd_wdata,
  input wire logic [31:0] cmd_rdata,
  input wire logic [11:0] supply_enable_output,
  input wire logic [11:0] supply_enable_output_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Idle cycle after the write keeps a later write off the checked pin
  sequence s_wr(v);
    cmd_wr && cmd_code == 8'hD2 && page < 4'hC && cmd_wdata[7:0] == v ##1 !cmd_wr;
  endsequence
  sequence s_pin(o, e);
    supply_enable_output[$past(page, 2)] == o && supply_enable_output_oe[$past(page, 2)] == e;
  endsequence
  property p_fon; s_wr(8'h41) |=> s_pin(1'b1, 1'b1); endproperty
  a_fon: assert property (p_fon) else $error("force on");
  property p_foff; s_wr(8'h42) |=> s_pin(1'b0, 1'b1); endproperty
  a_foff: assert property (p_foff) else $error("force off");
  property p_od; s_wr(8'h81) |=> s_pin(1'b0, 1'b1); endproperty
  a_od: assert property (p_od) else $error("od low");
  property p_rel; s_wr(8'hC1) |=> !supply_enable_output_oe[$past(page, 2)]; endproperty
  a_rel: assert property (p_rel) else $error("od release");
  property p_rd;
    cmd_wr && cmd_code == 8'hD2 && page < 4'hC ##1 cmd_code == 8'hD2 && $stable(page) && !cmd_wr
      |=> cmd_rdata == ($past(cmd_wdata, 2) & seoc_pkg::CFG_WR_MASK);
  endproperty
  a_rd: assert property (p_rd) else $error("readback");
  property p_zero; cmd_rdata[15:8] == 8'h00 && cmd_rdata[5:3] == 3'h0; endproperty
  a_zero: assert property (p_zero) else $error("zero bits");
  property p_code; cmd_code != 8'hD2 |=> cmd_rdata == 32'h0; endproperty
  a_code: assert property (p_code) else $error("other code");
  property p_rst;
    $fell(sys_rst) |=> supply_enable_output == 12'hFFF && supply_enable_output_oe == 12'hFFF;
  endproperty
  a_rst: assert property (p_rst) else $error("reset pins");
endmodule // seoc_top_asserts
bind seoc_top seoc_top_asserts chk_u (.sys_clk, .sys_rst, .page, .cmd_code, .cmd_wr,
  .cmd_wdata, .cmd_rdata, .supply_enable_output, .supply_enable_output_oe);

//--- dv/test_supply_enable_output_config.sv
`timescale 1ns/1ns
// ==========
// Bench
module test_supply_enable_output_config;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_wr = 1'b0;
  logic fault_line_two_in = 1'b0;
  logic ordering_link_line_in = 1'b0;
  logic [3:0] page = 4'h0;
  logic [7:0] cmd_code = 8'hD2;
  logic [31:0] cmd_wdata = 32'h0, cmd_rdata;
  logic [11:0] sequencer_enable = 12'h000, supply_enable_output, supply_enable_output_oe, lvl;
  logic [15:0] power_good, general_input = 16'h0000, src_sel = 16'h8000;
  logic [15:0] chan_alarm = 16'h0000;
  int error_cnt = 0;
  int check_count = 0;
  seoc_top dut_u (.sys_clk, .sys_rst, .page, .cmd_code, .cmd_wr, .cmd_wdata, .cmd_rdata,
    .sequencer_enable, .power_good, .general_input, .src_sel, .chan_alarm, .fault_line_two_in,
    .ordering_link_line_in, .supply_enable_output, .supply_enable_output_oe);
  seoc_supply_model sup_u (.sys_clk, .pin_out(supply_enable_output),
    .pin_oe(supply_enable_output_oe), .pin_level(lvl), .power_good);
  initial forever #10 sys_clk = ~sys_clk;
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %0t got %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] p, input logic [31:0] d);
    @(posedge sys_clk);
    page <= p;
    cmd_wdata <= d;
    cmd_wr <= 1'b1;
    @(posedge sys_clk);
    cmd_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] p, input logic [7:0] c, input logic [31:0] e);
    @(posedge sys_clk);
    page <= p;
    cmd_code <= c;
    repeat (2) @(posedge sys_clk);
    #1 chk(cmd_rdata, e);
    @(posedge sys_clk);
    cmd_code <= 8'hD2;
  endtask
  // Longest path: pin, supply, two sync stages, output
  task automatic pin(input int n, input logic e);
    repeat (7) @(posedge sys_clk);
    #1 chk(32'(lvl[n]), 32'(e));
    // Return on an edge so the next stimulus lands on the rising edge
    @(posedge sys_clk);
  endtask
  task automatic t_reset;
    rd(4'h0, 8'hD2, seoc_pkg::CFG_RESET);
    chk(32'(lvl), 32'hFFF);
    $display("reset ok");
  endtask
  task automatic t_regs;
    wr(4'h3, 32'hFFFF_FFFF);
    rd(4'h3, 8'hD2, seoc_pkg::CFG_WR_MASK);
    pin(3, 1'b0);
    wr(4'hC, 32'hFFFF_FFFF);
    rd(4'hC, 8'hD2, 32'h0);
    rd(4'h3, 8'hD1, 32'h0);
    $display("regs ok");
  endtask
  task automatic t_force;
    logic [7:0] cfg[4] = '{8'h41, 8'h42, 8'h81, 8'hC1};
    logic [3:0] lv = 4'h9;
    for (int i = 0; i < 4; i++) begin
      wr(4'h4, {24'h0, cfg[i]});
      pin(4, lv[i]);
    end
    $display("force ok");
  endtask
  task automatic t_supply;
    // Host configures while the reset config still holds the pin high and the supply on; channel setup lives outside this block
    wr(4'h6, 32'hFFFF_0040);
    sequencer_enable <= 12'h040;
    pin(6, 1'b1);
    sequencer_enable <= 12'hFBF;
    pin(6, 1'b0);
    $display("supply ok");
  endtask
  task automatic t_and;
    general_input <= 16'h8000;
    wr(4'h5, 32'h8003_0043);
    pin(5, 1'b1);
    general_input <= 16'h7FFF;
    pin(5, 1'b0);
    general_input <= 16'h8000;
    wr(4'h0, 32'h0000_0042);
    pin(5, 1'b0);
    $display("and ok");
  endtask
  task automatic t_or;
    wr(4'h7, 32'h0004_0044);
    chan_alarm <= 16'hFFFB;
    pin(7, 1'b0);
    chan_alarm <= 16'h0004;
    pin(7, 1'b1);
    $display("or ok");
  endtask
  task automatic t_special;
    wr(4'hA, 32'h0000_0045);
    wr(4'hB, 32'h0000_0045);
    wr(4'h9, 32'h0000_0045);
    fault_line_two_in <= 1'b1;
    pin(10, 1'b1);
    chk(32'(lvl[11:9]), 32'h2);
    ordering_link_line_in <= 1'b1;
    pin(11, 1'b1);
    $display("special ok");
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_force();
    t_supply();
    t_and();
    t_or();
    t_special();
    stop_test();
  end
endmodule // test_supply_enable_output_config
